// File: adc_conversion_setup.sv
// Conversion command, per-target setup registers and conversion sequencing
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module adc_conversion_setup #(
	parameter int COUNT_W = 24 // Conversion counter width
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// CPU module ports: data, address, control
	input  wire logic [15:0] i_port_data,
	input  wire logic [7:0]  i_port_addr,
	input  wire logic [15:0] i_port_ctrl,
	input  wire logic        i_port_ctrl_we,
	output logic      [15:0] o_read_data,
	output logic             o_read_valid,
	output logic             o_ctrl_busy,
	// CPU halt
	output logic             o_cpu_halt,
	// Converter result from the analog side
	input  wire logic [15:0] i_sample,
	// Analog setup for the active conversion
	output logic [3:0]       o_single_ended_select,
	output logic             o_target_ch_two,
	output logic             o_target_temp,
	output logic [4:0]       o_gain,
	output logic             o_gain_fixed,
	output logic             o_buffer_unity,
	output logic [2:0]       o_divisor,
	output logic [2:0]       o_resolution,
	output logic [3:0]       o_coarse_offset,
	output logic [2:0]       o_bias,
	output logic [1:0]       o_reference,
	output logic             o_converting
);
	conv_if conv ();

	// Register file
	logic [15:0] conversion_command;
	logic [15:0] channel1_setup_a;
	logic [15:0] channel1_setup_b;
	logic [15:0] channel2_setup_a;
	logic [15:0] channel2_setup_b;
	logic [15:0] temperature_setup_a;
	logic [15:0] temperature_setup_b;
	logic [15:0] result_ch_one;
	logic [15:0] result_ch_two;
	logic [15:0] result_temp;
	logic [15:0] next_command;
	logic [15:0] next_ch1_a;
	logic [15:0] next_ch1_b;
	logic [15:0] next_ch2_a;
	logic [15:0] next_ch2_b;
	logic [15:0] next_tmp_a;
	logic [15:0] next_tmp_b;
	logic [15:0] next_res1;
	logic [15:0] next_res2;
	logic [15:0] next_rest;
	logic [15:0] read_data;      // Registered read answer
	logic [15:0] next_read_data;
	logic        read_valid;
	logic        next_read_valid;

	// Sequencer state
	typedef enum logic [1:0] {IDLE, LAUNCH, RUN} seq_state_t;
	seq_state_t              state;
	seq_state_t              next_state;
	adc_setup_pkg::target_t  target;      // Target latched at launch
	adc_setup_pkg::target_t  next_target;
	adc_setup_pkg::target_t  pick;        // Target chosen from command
	logic [3:0]              single_ended_select;
	logic                    start_channel_one;
	logic                    start_channel_two;
	logic                    start_temperature;
	logic [15:0]             setup_a;     // Setup A of the active target
	logic [15:0]             setup_b;     // Setup B of the active target
	logic                    wr;
	logic                    rd;

	// Command fields
	assign single_ended_select = conversion_command[`CMD_SE_HI:`CMD_SE_LO];
	assign start_channel_one   = conversion_command[`CMD_START_CH1];
	assign start_channel_two   = conversion_command[`CMD_START_CH2];
	assign start_temperature   = conversion_command[`CMD_START_TMP];

	// Port operation strobes; a write of the control port with go set
	assign wr = i_port_ctrl_we && i_port_ctrl[`CTL_GO] && !i_port_ctrl[`CTL_READ];
	assign rd = i_port_ctrl_we && i_port_ctrl[`CTL_GO] && i_port_ctrl[`CTL_READ];

	// Target priority: channel 1, then channel 2, then temperature alone
	always_comb begin
		if (start_channel_one) begin
			pick = adc_setup_pkg::TGT_CH1;
		end else if (start_channel_two) begin
			pick = adc_setup_pkg::TGT_CH2;
		end else if (start_temperature && single_ended_select == `SE_DIFF) begin
			pick = adc_setup_pkg::TGT_TEMP;
		end else begin
			// Temperature with nonzero selector is undefined; do nothing
			pick = adc_setup_pkg::TGT_NONE;
		end
	end

	// Setup registers of the active target
	always_comb begin
		unique case (target)
			adc_setup_pkg::TGT_CH2: begin
				setup_a = channel2_setup_a;
				setup_b = channel2_setup_b;
			end
			adc_setup_pkg::TGT_TEMP: begin
				setup_a = temperature_setup_a;
				setup_b = temperature_setup_b;
			end
			default: begin
				setup_a = channel1_setup_a;
				setup_b = channel1_setup_b;
			end
		endcase
	end

	// Sequencer next state: launch, wait for done, write result, clear start
	always_comb begin
		next_state  = state;
		next_target = target;
		next_res1   = result_ch_one;
		next_res2   = result_ch_two;
		next_rest   = result_temp;
		unique case (state)
			IDLE: begin
				// Launch only when no port write is landing this cycle
				if (pick != adc_setup_pkg::TGT_NONE && !wr) begin
					next_target = pick;
					next_state  = LAUNCH;
				end
			end
			LAUNCH: next_state = RUN;
			RUN: begin
				if (conv.done) begin
					unique case (target)
						adc_setup_pkg::TGT_CH1:  next_res1 = conv.result;
						adc_setup_pkg::TGT_CH2:  next_res2 = conv.result;
						adc_setup_pkg::TGT_TEMP: next_rest = conv.result;
						default:                 next_res1 = result_ch_one;
					endcase
					next_target = adc_setup_pkg::TGT_NONE;
					next_state  = IDLE;
				end
			end
		endcase
	end

	// Launch request to the timer with resolution and divisor of target
	assign conv.start      = (state == LAUNCH);
	assign conv.divisor    = setup_a[`SA_DIV_HI:`SA_DIV_LO];
	assign conv.resolution = setup_a[`SA_RES_HI:`SA_RES_LO];

	// Register writes, masked; the finishing conversion clears its start bit
	always_comb begin
		next_command = conversion_command;
		next_ch1_a   = channel1_setup_a;
		next_ch1_b   = channel1_setup_b;
		next_ch2_a   = channel2_setup_a;
		next_ch2_b   = channel2_setup_b;
		next_tmp_a   = temperature_setup_a;
		next_tmp_b   = temperature_setup_b;
		// CPU is halted while running, so writes only land in IDLE
		if (wr && state == IDLE) begin
			unique case (i_port_addr)
				`OFF_COMMAND:     next_command = i_port_data & `MASK_COMMAND;
				`OFF_CH1_SETUP_A: next_ch1_a   = i_port_data & `MASK_SETUP_A;
				`OFF_CH1_SETUP_B: next_ch1_b   = i_port_data & `MASK_SETUP_B_CH;
				`OFF_CH2_SETUP_A: next_ch2_a   = i_port_data & `MASK_SETUP_A;
				`OFF_CH2_SETUP_B: next_ch2_b   = i_port_data & `MASK_SETUP_B_CH;
				`OFF_TMP_SETUP_A: next_tmp_a   = i_port_data & `MASK_SETUP_A;
				`OFF_TMP_SETUP_B: next_tmp_b   = i_port_data & `MASK_SETUP_B_TMP;
				default:          next_command = conversion_command;
			endcase
		end
		if (state == RUN && conv.done) begin
			unique case (target)
				adc_setup_pkg::TGT_CH1:  next_command[`CMD_START_CH1] = 1'b0;
				adc_setup_pkg::TGT_CH2:  next_command[`CMD_START_CH2] = 1'b0;
				adc_setup_pkg::TGT_TEMP: next_command[`CMD_START_TMP] = 1'b0;
				default:                 next_command = conversion_command;
			endcase
		end
	end

	// Read answer; unmapped addresses read zero
	always_comb begin
		next_read_data  = read_data;
		next_read_valid = 1'b0;
		if (rd && state == IDLE) begin
			next_read_valid = 1'b1;
			unique case (i_port_addr)
				`OFF_COMMAND:     next_read_data = conversion_command;
				`OFF_RESULT_CH1:  next_read_data = result_ch_one;
				`OFF_CH1_SETUP_A: next_read_data = channel1_setup_a;
				`OFF_CH1_SETUP_B: next_read_data = channel1_setup_b;
				`OFF_RESULT_CH2:  next_read_data = result_ch_two;
				`OFF_CH2_SETUP_A: next_read_data = channel2_setup_a;
				`OFF_CH2_SETUP_B: next_read_data = channel2_setup_b;
				`OFF_RESULT_TEMP: next_read_data = result_temp;
				`OFF_TMP_SETUP_A: next_read_data = temperature_setup_a;
				`OFF_TMP_SETUP_B: next_read_data = temperature_setup_b;
				default:          next_read_data = 16'h0000;
			endcase
		end
	end

	// All state registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state               <= IDLE;
			target              <= adc_setup_pkg::TGT_NONE;
			conversion_command  <= `RST_COMMAND;
			channel1_setup_a    <= `RST_SETUP_A;
			channel1_setup_b    <= `RST_SETUP_B;
			channel2_setup_a    <= `RST_SETUP_A;
			channel2_setup_b    <= `RST_SETUP_B;
			temperature_setup_a <= `RST_SETUP_A;
			temperature_setup_b <= `RST_SETUP_B;
			result_ch_one       <= `RST_RESULT;
			result_ch_two       <= `RST_RESULT;
			result_temp         <= `RST_RESULT;
			read_data           <= 16'h0000;
			read_valid          <= 1'b0;
		end else begin
			state               <= next_state;
			target              <= next_target;
			conversion_command  <= next_command;
			channel1_setup_a    <= next_ch1_a;
			channel1_setup_b    <= next_ch1_b;
			channel2_setup_a    <= next_ch2_a;
			channel2_setup_b    <= next_ch2_b;
			temperature_setup_a <= next_tmp_a;
			temperature_setup_b <= next_tmp_b;
			result_ch_one       <= next_res1;
			result_ch_two       <= next_res2;
			result_temp         <= next_rest;
			read_data           <= next_read_data;
			read_valid          <= next_read_valid;
		end
	end

	// Conversion timer
	conv_timer #(
		.COUNT_W (COUNT_W)
	) u_timer (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_sample (i_sample),
		.conv     (conv.timer)
	);

	// Analog setup outputs; selector only meaningful while converting
	always_comb begin
		o_single_ended_select = single_ended_select;
		o_target_ch_two       = (target == adc_setup_pkg::TGT_CH2);
		o_target_temp         = (target == adc_setup_pkg::TGT_TEMP);
		o_gain_fixed          = (target != adc_setup_pkg::TGT_TEMP)
			&& single_ended_select >= `SE_FIXED_LO
			&& single_ended_select <= `SE_FIXED_HI;
		o_gain                = o_gain_fixed ? `GAIN_FIXED_CODE
			: setup_a[`SA_GAIN_HI:`SA_GAIN_LO];
		o_buffer_unity        = (target != adc_setup_pkg::TGT_TEMP)
			&& (single_ended_select == `SE_DAC_SMALL
			|| single_ended_select == `SE_DAC_LARGE);
		o_divisor             = setup_a[`SA_DIV_HI:`SA_DIV_LO];
		o_resolution          = setup_a[`SA_RES_HI:`SA_RES_LO];
		o_coarse_offset       = setup_a[`SA_CO_HI:`SA_CO_LO];
		o_bias                = setup_b[`SB_BIAS_HI:`SB_BIAS_LO];
		o_reference           = setup_b[`SB_REF_HI:`SB_REF_LO];
	end

	// Halt while a conversion is pending or running
	assign o_cpu_halt   = (state != IDLE);
	assign o_converting = (state == RUN);
	assign o_ctrl_busy  = (state != IDLE);
	assign o_read_data  = read_data;
	assign o_read_valid = read_valid;
endmodule

// File: adc_conversion_setup_tb.sv
// Self-checking bench for the conversion setup block
`timescale 1ns/1ps
module adc_conversion_setup_tb;
	logic        i_clk = 1'b0;           // System clock
	logic        i_rst = 1'b1;           // Synchronous reset
	logic [15:0] i_port_data = 16'h0000; // Write data
	logic [7:0]  i_port_addr = 8'h00;    // Register address
	logic [15:0] i_port_ctrl = 16'h0000; // Go and direction
	logic        i_port_ctrl_we = 1'b0;  // Control strobe
	logic [15:0] i_sample;               // From sensor model
	logic [15:0] o_read_data;
	logic        o_read_valid, o_ctrl_busy, o_cpu_halt, o_target_ch_two, o_target_temp;
	logic        o_gain_fixed, o_buffer_unity, o_converting;
	logic [3:0]  o_single_ended_select, o_coarse_offset;
	logic [4:0]  o_gain;
	logic [2:0]  o_divisor, o_resolution, o_bias;
	logic [1:0]  o_reference;
	logic [15:0] expq[$];          // Pending read answers
	logic [15:0] shadow [0:9];     // Expected setup contents
	logic [31:0] lfsr = 32'h43a4;  // Random source state
	logic [15:0] d;                // Random write data
	int          err_total = 0;
	int          total_checks = 0;

	adc_conversion_setup i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_port_data(i_port_data), .i_port_addr(i_port_addr),
		.i_port_ctrl(i_port_ctrl), .i_port_ctrl_we(i_port_ctrl_we), .o_read_data(o_read_data),
		.o_read_valid(o_read_valid), .o_ctrl_busy(o_ctrl_busy), .o_cpu_halt(o_cpu_halt),
		.i_sample(i_sample), .o_single_ended_select(o_single_ended_select),
		.o_target_ch_two(o_target_ch_two), .o_target_temp(o_target_temp), .o_gain(o_gain),
		.o_gain_fixed(o_gain_fixed), .o_buffer_unity(o_buffer_unity), .o_divisor(o_divisor),
		.o_resolution(o_resolution), .o_coarse_offset(o_coarse_offset), .o_bias(o_bias),
		.o_reference(o_reference), .o_converting(o_converting));

	sensor_model i_model (
		.i_clk(i_clk), .i_rst(i_rst), .i_conv(o_converting), .i_se(o_single_ended_select),
		.i_ch_two(o_target_ch_two), .i_temp(o_target_temp), .o_sample(i_sample));

	// 100 ns clock
	initial begin
		forever #50 i_clk = ~i_clk;
	end

	// Shift-register random source
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Single comparison point
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One port operation: strobe for one cycle, then let it settle
	task automatic port_op(input logic is_rd, input logic [7:0] a, input logic [15:0] wd);
		@(posedge i_clk);
		#5;
		i_port_addr = a;
		i_port_data = wd;
		i_port_ctrl = {1'b1, is_rd, 14'h0000};
		i_port_ctrl_we = 1'b1;
		@(posedge i_clk);
		#5;
		i_port_ctrl_we = 1'b0;
		i_port_ctrl = 16'h0000;
		repeat (2) @(posedge i_clk);
	endtask

	// Read with the expected answer noted first
	task automatic rd_exp(input logic [7:0] a, input logic [15:0] exp);
		expq.push_back(exp);
		port_op(1'b1, a, 16'h0000);
	endtask

	// Bounded wait for the halt to drop
	task automatic wait_idle();
		int n;
		n = 0;
		while ((o_cpu_halt !== 1'b0 || o_ctrl_busy !== 1'b0) && n < 3000) begin
			@(posedge i_clk);
			#5;
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			stop_test();
		end
	endtask

	// Launch, check the active setup mid-run, then result and cleared start bit
	task automatic conv(input logic [15:0] cmd, input int t);
		logic [15:0] sa;
		logic [15:0] sb;
		logic [3:0]  se;
		logic        fx;
		logic [31:0] got;
		logic [31:0] want;
		se = cmd[11:8];
		sa = shadow[3 * t - 1];
		sb = shadow[3 * t];
		fx = (se inside {[4'h4:4'h7]}) && t != 3;
		port_op(1'b0, 8'h00, cmd);
		repeat (2) @(posedge i_clk);
		#5;
		// Halt and busy must both stand at this one mid-run sample
		got = {7'h00, o_cpu_halt, o_ctrl_busy, o_converting, o_target_ch_two, o_target_temp,
			o_gain_fixed, o_buffer_unity, o_gain, o_divisor, o_resolution, o_coarse_offset, o_bias};
		want = {7'h00, 2'b11, 1'b1, t == 2, t == 3, fx, (se inside {4'h6, 4'h7}) && t != 3,
			fx ? 5'h1f : sa[15:11], sa[10:8], sa[6:4], sa[3:0], sb[6:4]};
		check(got, want);
		if (t != 3) check({30'h0, o_reference}, {30'h0, sb[1:0]});
		wait_idle();
		rd_exp(8'(3 * t - 2), {8'h5a, se, 2'b00, t == 2, t == 3});
		rd_exp(8'h00, cmd & 16'h0f07 & ~(16'h0001 << (3 - t)));
	endtask

	// Read answers taken off the queue as they appear
	always @(negedge i_clk) begin
		if (o_read_valid === 1'b1) begin
			if (expq.size() == 0) check(32'h1, 32'h0);
			else check({16'h0, o_read_data}, {16'h0, expq.pop_front()});
		end
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk);
		#5;
		i_rst = 1'b0;
		// Reset values, address 0x0a unmapped
		for (int a = 0; a < 11; a++) begin
			rd_exp(a[7:0], (a % 3 == 0 && a > 0 && a < 10) ? 16'h0070 : 16'h0000);
		end
		// Result register is read-only; unused command bits drop
		port_op(1'b0, 8'h01, 16'hffff);
		rd_exp(8'h01, 16'h0000);
		port_op(1'b0, 8'h00, 16'hf0f8);
		rd_exp(8'h00, 16'h0000);
		// Random setups; divisor and resolution kept at zero for short conversions
		for (int a = 2; a < 10; a++) begin
			if (a % 3 != 1) begin
				lfsr = next_rand(lfsr);
				d = (a % 3 == 2) ? (lfsr[15:0] & 16'hf88f) : lfsr[15:0];
				shadow[a] = d & ((a % 3 == 2) ? 16'hff7f : (a == 9) ? 16'h0070 : 16'h0073);
				port_op(1'b0, a[7:0], d);
				rd_exp(a[7:0], shadow[a]);
			end
		end
		// Supply (selector 0100) is never measured, so no reference is forced
		conv(16'h0004, 1);
		conv(16'h0002, 2);
		conv(16'h0001, 3); // selector left at zero
		conv(16'h0804, 1); // no temperature start beside a selector
		conv(16'h0203, 2);
		conv(16'h0704, 1);
		wait (expq.size() == 0);
		stop_test();
	end
endmodule

// File: adc_setup_checker.sv
// Concurrent checks on the conversion setup block's ports
`timescale 1ns/1ps
module adc_setup_checker #(
	parameter int COUNT_W = 24 // Same as the block
) (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst,
	// Register port
	input wire logic [15:0] i_port_data,
	input wire logic [7:0]  i_port_addr,
	input wire logic [15:0] i_port_ctrl,
	input wire logic        i_port_ctrl_we,
	input wire logic        o_read_valid,
	input wire logic        o_ctrl_busy,
	input wire logic        o_cpu_halt,
	// Analog setup
	input wire logic [3:0]  o_single_ended_select,
	input wire logic        o_target_ch_two,
	input wire logic        o_target_temp,
	input wire logic [4:0]  o_gain,
	input wire logic        o_gain_fixed,
	input wire logic        o_buffer_unity,
	input wire logic        o_converting
);
	logic [COUNT_W-1:0] conv_len;      // Cycles spent converting
	logic [COUNT_W-1:0] next_conv_len; // Next count

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Run-length counter, cleared between conversions
	always_comb begin
		next_conv_len = o_converting ? conv_len + 1'b1 : '0;
	end
	always_ff @(posedge i_clk) begin
		conv_len <= i_rst ? '0 : next_conv_len;
	end

	// Accepted write of the command register
	sequence s_cmd_write;
		i_port_ctrl_we && i_port_ctrl[15] && !i_port_ctrl[14] && i_port_addr == 8'h00 && !o_ctrl_busy;
	endsequence
	// Accepted read
	sequence s_read_taken;
		i_port_ctrl_we && i_port_ctrl[15] && i_port_ctrl[14] && !o_ctrl_busy;
	endsequence
	// End of a conversion
	sequence s_conv_end;
		$fell(o_converting);
	endsequence

	AST_SE_FIELD: assert property (s_cmd_write |=> o_single_ended_select == $past(i_port_data[11:8]))
		else $error("selector not taken from command bits");
	AST_LAUNCH: assert property ((s_cmd_write ##0 i_port_data[2:1] != 2'b00) |-> ##[1:3] o_cpu_halt)
		else $error("no halt after channel start");
	AST_HALT_CONV: assert property (o_converting |-> o_cpu_halt)
		else $error("converting without halt");
	AST_HALT_END: assert property (s_conv_end |-> ##[0:3] !o_cpu_halt)
		else $error("halt held after conversion");
	AST_CONV_LEN: assert property (s_conv_end |-> conv_len >= 1023)
		else $error("conversion too short");
	AST_TEMP_ONLY: assert property (o_target_temp |-> o_single_ended_select == 4'h0 && !o_target_ch_two)
		else $error("temperature target with selector set");
	AST_GAIN_FIXED: assert property (o_gain_fixed == (o_single_ended_select inside {[4'h4:4'h7]} && !o_target_temp))
		else $error("fixed gain flag wrong");
	AST_GAIN_CODE: assert property (o_gain_fixed |-> o_gain == 5'h1f)
		else $error("fixed gain code wrong");
	AST_UNITY: assert property (o_buffer_unity == (o_single_ended_select inside {4'h6, 4'h7} && !o_target_temp))
		else $error("unity buffer flag wrong");
	AST_READ_VALID: assert property (s_read_taken |-> ##[1:2] o_read_valid)
		else $error("read answer missing");
endmodule

bind adc_conversion_setup adc_setup_checker #(.COUNT_W(COUNT_W)) i_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_port_data(i_port_data), .i_port_addr(i_port_addr),
	.i_port_ctrl(i_port_ctrl), .i_port_ctrl_we(i_port_ctrl_we), .o_read_valid(o_read_valid),
	.o_ctrl_busy(o_ctrl_busy), .o_cpu_halt(o_cpu_halt),
	.o_single_ended_select(o_single_ended_select), .o_target_ch_two(o_target_ch_two),
	.o_target_temp(o_target_temp), .o_gain(o_gain), .o_gain_fixed(o_gain_fixed),
	.o_buffer_unity(o_buffer_unity), .o_converting(o_converting));

// File: adc_setup_defs.svh
// Constants for the conversion setup block: offsets, fields, reset values, codes
`ifndef ADC_SETUP_DEFS_SVH
`define ADC_SETUP_DEFS_SVH

// Module register addresses (low eight bits of the address port)
`define OFF_COMMAND      8'h00
`define OFF_RESULT_CH1   8'h01
`define OFF_CH1_SETUP_A  8'h02
`define OFF_CH1_SETUP_B  8'h03
`define OFF_RESULT_CH2   8'h04
`define OFF_CH2_SETUP_A  8'h05
`define OFF_CH2_SETUP_B  8'h06
`define OFF_RESULT_TEMP  8'h07
`define OFF_TMP_SETUP_A  8'h08
`define OFF_TMP_SETUP_B  8'h09

// Reset values
`define RST_COMMAND      16'h0000
`define RST_SETUP_A      16'h0000
`define RST_SETUP_B      16'h0070
`define RST_RESULT       16'h0000

// Writable bit masks; unused bits read as zero
`define MASK_COMMAND     16'h0f07
`define MASK_SETUP_A     16'hff7f
`define MASK_SETUP_B_CH  16'h0073
`define MASK_SETUP_B_TMP 16'h0070

// Command register fields
`define CMD_SE_HI        11
`define CMD_SE_LO        8
`define CMD_START_CH1    2
`define CMD_START_CH2    1
`define CMD_START_TMP    0

// Setup A fields
`define SA_GAIN_HI       15
`define SA_GAIN_LO       11
`define SA_DIV_HI        10
`define SA_DIV_LO        8
`define SA_RES_HI        6
`define SA_RES_LO        4
`define SA_CO_HI         3
`define SA_CO_LO         0

// Setup B fields
`define SB_BIAS_HI       6
`define SB_BIAS_LO       4
`define SB_REF_HI        1
`define SB_REF_LO        0

// Control port bits
`define CTL_GO           15
`define CTL_READ         14

// Single-ended selector codes
`define SE_DIFF          4'h0
`define SE_FIXED_LO      4'h4
`define SE_FIXED_HI      4'h7
`define SE_DAC_SMALL     4'h6
`define SE_DAC_LARGE     4'h7

// Fixed-gain marker code on the gain output (not a programmable code)
`define GAIN_FIXED_CODE  5'h1f

// Conversion length: base converter clocks and divisor base shift
`define DIV_BASE_SHIFT   2
`define CLKS_RES0        12'h100
`define CLKS_RES1        12'h140
`define CLKS_RES2        12'h200
`define CLKS_RES3        12'h280
`define CLKS_RES4        12'h320
`define CLKS_RES5        12'h500
`define CLKS_RES6        12'h800

`endif

// File: adc_setup_pkg.sv
// Types shared by the conversion setup block
package adc_setup_pkg;
	// Conversion target
	typedef enum logic [1:0] {
		TGT_NONE,
		TGT_CH1,
		TGT_CH2,
		TGT_TEMP
	} target_t;
endpackage

// File: conv_if.sv
// Request and completion between the controller and the conversion timer
`timescale 1ns/1ps
interface conv_if;
	logic        start;      // One-cycle launch pulse
	logic [2:0]  divisor;    // Converter clock divisor code
	logic [2:0]  resolution; // Resolution code
	logic        busy;       // Conversion running
	logic        done;       // One-cycle finish pulse
	logic [15:0] result;     // Result word, valid with done
	modport ctrl (output start, output divisor, output resolution,
		input busy, input done, input result);
	modport timer (input start, input divisor, input resolution,
		output busy, output done, output result);
endinterface

// File: conv_timer.sv
// Times one conversion in system clocks and captures the converter result
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module conv_timer #(
	parameter int COUNT_W = 24 // Wide enough for 2048 x 128 x 4
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Converter sample data
	input  wire logic [15:0] i_sample,
	// Controller side
	conv_if.timer     conv
);
	logic [COUNT_W-1:0] count;      // Remaining system clocks
	logic [COUNT_W-1:0] next_count;
	logic               busy;
	logic               next_busy;
	logic [15:0]        result;
	logic [15:0]        next_result;
	logic               done;
	logic               next_done;
	logic [11:0]        base;       // Converter clocks per conversion

	// Converter clocks per resolution code; code 111 treated as longest
	always_comb begin
		unique case (conv.resolution)
			3'h0: base = `CLKS_RES0;
			3'h1: base = `CLKS_RES1;
			3'h2: base = `CLKS_RES2;
			3'h3: base = `CLKS_RES3;
			3'h4: base = `CLKS_RES4;
			3'h5: base = `CLKS_RES5;
			default: base = `CLKS_RES6;
		endcase
	end

	// Next state: load length on start, count down, pulse done when the count reaches one
	always_comb begin
		next_count  = count;
		next_busy   = busy;
		next_result = result;
		next_done   = 1'b0;
		if (conv.start && !busy) begin
			// Length = clocks x (4 << divisor) system clocks
			next_count = COUNT_W'(({12'h000, base} << conv.divisor) << `DIV_BASE_SHIFT);
			next_busy  = 1'b1;
		end else if (busy) begin
			if (count <= COUNT_W'(1)) begin
				next_busy   = 1'b0;
				next_done   = 1'b1;
				next_result = i_sample;
			end else begin
				next_count = count - COUNT_W'(1);
			end
		end
	end

	// Registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count  <= '0;
			busy   <= 1'b0;
			result <= `RST_RESULT;
			done   <= 1'b0;
		end else begin
			count  <= next_count;
			busy   <= next_busy;
			result <= next_result;
			done   <= next_done;
		end
	end

	assign conv.busy   = busy;
	assign conv.done   = done;
	assign conv.result = result;
endmodule

// File: sensor_model.sv
// Behavioural sensor and converter front end that answers the block's conversions
`timescale 1ns/1ps
module sensor_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Active conversion setup from the block
	input  wire logic        i_conv,
	input  wire logic [3:0]  i_se,
	input  wire logic        i_ch_two,
	input  wire logic        i_temp,
	// Converter result toward the block
	output logic      [15:0] o_sample
);
	// Result word encodes source and target so a misrouted conversion shows up
	// Outside a conversion the word toggles, so a stale capture never matches
	// Known start value from reset, so the toggling word is never unknown
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sample <= 16'h0000;
		end else if (i_conv) begin
			o_sample <= {8'h5a, i_se, 2'b00, i_ch_two, i_temp};
		end else begin
			o_sample <= ~o_sample;
		end
	end
endmodule
